// File: logic/display_status_readback.sv
// Read-only status commands of the display driver: holds fields and answers queries.
// Function
// - Orientation bit D1 reports source scan direction.
// - Orientation bit D0 reports gate scan direction.
// - Orientation bit D3 reports BGR colour order.
// - Pixel format low bits give interface format.
// - Image bits D4/D3 report all-on, all-off.
// - Image low bits carry gamma selection.
// - Signal bit D7 reports tear line enabled.
// - Signal bit D6 reports tear output mode.
// - Signal bit D0 reports link error flag.
// - Queries answered in every power state.
// - Orientation bits follow last access-control write.
`timescale 1ns/1ps
`include "display_status_defines.svh"

module display_status_readback
   import display_status_pkg::*;
(
   // Clock and reset
   input  wire logic       clk,
   input  wire logic       resetn,
   input  wire logic       soft_reset,
   // Read request from the link command decoder
   input  wire logic       cmd_valid,
   input  wire byte_t      cmd_code,
   // Memory access control write
   input  wire logic       memory_access_control_wr,
   input  wire byte_t      memory_access_control_data,
   // Colour format setting write
   input  wire logic       colour_format_setting_wr,
   input  wire logic [2:0] colour_format_setting_data,
   // Image mode updates
   input  wire logic       image_wr,
   input  wire logic       image_all_on,
   input  wire logic       image_all_off,
   input  wire logic [2:0] image_gamma,
   // Tear effect updates
   input  wire logic       te_wr,
   input  wire logic       te_on_data,
   input  wire logic       te_mode_data,
   // Link error events
   input  wire logic       link_error,
   input  wire logic       ack_error_report,
   // Answer to the link
   output logic            resp_valid,
   output byte_t           resp_data
);

   // ==========================================================================
   // Held status fields
   logic       bgr_r;
   logic       src_dir_r;
   logic       gate_scan_dir_r;
   logic [2:0] pixel_format_code_r;
   logic       all_on_r;
   logic       all_off_r;
   logic [2:0] gamma_r;
   logic       te_on_r;
   logic       te_mode_r;
   logic       link_err_r;
   logic       link_err_nxt;
   logic       resp_valid_r;
   byte_t      resp_data_r;

   // ==========================================================================
   // Command decoding
   query_t query;
   logic   known_query;
   byte_t  status_byte;

   // Maps a command code onto the query it selects.
   function automatic query_t query_of(input byte_t code);
      query_t q;
      q = QUERY_NONE;
      case (code)
         `ORIENTATION_QUERY:  q = QUERY_ORIENT;
         `PIXEL_FORMAT_QUERY: q = QUERY_PIXFMT;
         `IMAGE_MODE_QUERY:   q = QUERY_IMAGE;
         `SIGNAL_MODE_QUERY:  q = QUERY_SIGNAL;
         default:             q = QUERY_NONE;
      endcase
      return q;
   endfunction

   // Decoding ignores power state on purpose: sleep and idle never gate a read.
   assign query       = query_of(cmd_code);
   assign known_query = cmd_valid && (query != QUERY_NONE);

   // ==========================================================================
   // Byte assembly
   status_byte_select u_select (
      .query             (query),
      .bgr               (bgr_r),
      .src_dir           (src_dir_r),
      .gate_scan_dir     (gate_scan_dir_r),
      .pixel_format_code (pixel_format_code_r),
      .all_on            (all_on_r),
      .all_off           (all_off_r),
      .gamma_sel         (gamma_r),
      .te_on             (te_on_r),
      .te_mode           (te_mode_r),
      .link_err          (link_err_r),
      .status_byte       (status_byte)
   );

   // ==========================================================================
   // Error flag: a new error in the clearing cycle wins, so no event is lost.
   assign link_err_nxt = link_error ? 1'b1 : (ack_error_report ? 1'b0 : link_err_r);

   // ==========================================================================
   // Orientation fields; software reset takes priority over a same-cycle write.
   always_ff @(posedge clk) begin
      if (!resetn || soft_reset) begin
         bgr_r           <= `FIELD_BIT_RESET;
         src_dir_r       <= `FIELD_BIT_RESET;
         gate_scan_dir_r <= `FIELD_BIT_RESET;
      end else if (memory_access_control_wr) begin
         bgr_r           <= memory_access_control_data[`ORIENT_BGR_BIT];
         src_dir_r       <= memory_access_control_data[`ORIENT_SRC_BIT];
         gate_scan_dir_r <= memory_access_control_data[`ORIENT_GATE_BIT];
      end
   end

   // Pixel format field; undefined codes are stored and returned as written.
   always_ff @(posedge clk) begin
      if (!resetn || soft_reset) begin
         pixel_format_code_r <= `PIXEL_FORMAT_RESET;
      end else if (colour_format_setting_wr) begin
         pixel_format_code_r <= colour_format_setting_data;
      end
   end

   // Image mode fields.
   always_ff @(posedge clk) begin
      if (!resetn || soft_reset) begin
         all_on_r  <= `FIELD_BIT_RESET;
         all_off_r <= `FIELD_BIT_RESET;
         gamma_r   <= `GAMMA_RESET;
      end else if (image_wr) begin
         all_on_r  <= image_all_on;
         all_off_r <= image_all_off;
         gamma_r   <= image_gamma;
      end
   end

   // Signal mode fields.
   always_ff @(posedge clk) begin
      if (!resetn || soft_reset) begin
         te_on_r    <= `FIELD_BIT_RESET;
         te_mode_r  <= `FIELD_BIT_RESET;
         link_err_r <= `FIELD_BIT_RESET;
      end else begin
         if (te_wr) begin
            te_on_r   <= te_on_data;
            te_mode_r <= te_mode_data;
         end
         link_err_r <= link_err_nxt;
      end
   end

   // ==========================================================================
   // Answer register: one byte, valid one cycle after each known query.
   // Unknown codes draw no answer so another decoder may claim them.
   always_ff @(posedge clk) begin
      if (!resetn) begin
         resp_valid_r <= 1'b0;
         resp_data_r  <= `ZERO_BYTE;
      end else begin
         resp_valid_r <= known_query;
         if (known_query) begin
            resp_data_r <= status_byte;
         end
      end
   end

   assign resp_valid = resp_valid_r;
   assign resp_data  = resp_data_r;

   // ==========================================================================
   // Assertions
   default clocking cb @(posedge clk); endclocking
   default disable iff (!resetn);

   sequence orient_read;
      cmd_valid && cmd_code == `ORIENTATION_QUERY;
   endsequence

   AST_SRC_DIR: assert property (
      orient_read |=> resp_valid && resp_data[`ORIENT_SRC_BIT] == $past(src_dir_r))
      else $error("Source direction bit wrong in orientation answer.");

   AST_GATE_DIR: assert property (
      orient_read |=> resp_data[`ORIENT_GATE_BIT] == $past(gate_scan_dir_r))
      else $error("Gate direction bit wrong in orientation answer.");

   AST_COLOUR_ORDER: assert property (
      orient_read |=> resp_data[`ORIENT_BGR_BIT] == $past(bgr_r)
                      && resp_data[7:4] == 4'h0 && !resp_data[2])
      else $error("Colour order or zero bits wrong in orientation answer.");

   AST_PIXFMT: assert property (
      cmd_valid && cmd_code == `PIXEL_FORMAT_QUERY
      |=> resp_valid && resp_data == {5'h00, $past(pixel_format_code_r)})
      else $error("Pixel format answer wrong.");

   AST_IMAGE_FLAGS: assert property (
      image_wr && !soft_reset ##1 cmd_valid && cmd_code == `IMAGE_MODE_QUERY && !image_wr
      |=> resp_data[`IMAGE_ALL_ON_BIT] == $past(image_all_on, 2)
          && resp_data[`IMAGE_ALL_OFF_BIT] == $past(image_all_off, 2))
      else $error("Image mode flags do not follow last write.");

   AST_GAMMA: assert property (
      cmd_valid && cmd_code == `IMAGE_MODE_QUERY
      |=> resp_data[2:0] == $past(gamma_r) && resp_data[7:5] == 3'h0)
      else $error("Gamma field wrong in image answer.");

   AST_TE_ON: assert property (
      cmd_valid && cmd_code == `SIGNAL_MODE_QUERY
      |=> resp_data[`SIGNAL_TE_ON_BIT] == $past(te_on_r))
      else $error("Tear line enable bit wrong.");

   AST_TE_MODE: assert property (
      cmd_valid && cmd_code == `SIGNAL_MODE_QUERY
      |=> resp_data[`SIGNAL_TE_MODE_BIT] == $past(te_mode_r) && resp_data[5:1] == 5'h00)
      else $error("Tear mode bit wrong.");

   AST_ERR_SET_WINS: assert property (
      link_error && !soft_reset |=> link_err_r)
      else $error("Link error lost.");

   AST_ERR_CLEAR: assert property (
      ack_error_report && !link_error && !soft_reset |=> !link_err_r)
      else $error("Error flag not cleared by acknowledge.");

   AST_ONE_BYTE: assert property (
      resp_valid == $past(cmd_valid && query_of(cmd_code) != QUERY_NONE))
      else $error("Answer count does not match known queries.");

   AST_ORIENT_WRITE: assert property (
      memory_access_control_wr && !soft_reset
      |=> {bgr_r, src_dir_r, gate_scan_dir_r} == {$past(memory_access_control_data[3]),
          $past(memory_access_control_data[1]), $past(memory_access_control_data[0])})
      else $error("Orientation fields do not follow access-control write.");

   AST_SOFT_RESET: assert property (
      soft_reset |=> pixel_format_code_r == `PIXEL_FORMAT_RESET && !link_err_r
                     && !te_on_r && !all_on_r && !bgr_r && gamma_r == `GAMMA_RESET)
      else $error("Software reset did not restore defaults.");

   COV_ORIENT: cover property (orient_read ##1 resp_valid);
   COV_BACK_TO_BACK: cover property (known_query ##1 known_query ##1 resp_valid);
   COV_ERR_RACE: cover property (link_error && ack_error_report);
   COV_SIGNAL_ERR: cover property (link_err_r && cmd_valid && cmd_code == `SIGNAL_MODE_QUERY);

endmodule // display_status_readback

// File: logic/display_status_defines.svh
// Command codes, field positions, reset values and fixed encodings of the status readback block.
`ifndef DISPLAY_STATUS_DEFINES_SVH
`define DISPLAY_STATUS_DEFINES_SVH

// ==========================================================================
// Read command codes answered by this block
`define ORIENTATION_QUERY   8'h0b
`define PIXEL_FORMAT_QUERY  8'h0c
`define IMAGE_MODE_QUERY    8'h0d
`define SIGNAL_MODE_QUERY   8'h0e

// ==========================================================================
// Bit positions inside the answer bytes
`define ORIENT_BGR_BIT      3
`define ORIENT_SRC_BIT      1
`define ORIENT_GATE_BIT     0
`define IMAGE_ALL_ON_BIT    4
`define IMAGE_ALL_OFF_BIT   3
`define SIGNAL_TE_ON_BIT    7
`define SIGNAL_TE_MODE_BIT  6
`define SIGNAL_ERR_BIT      0

// ==========================================================================
// Reset values and fixed codes
`define PIXEL_FORMAT_RESET  3'h7
`define GAMMA_RESET         3'h0
`define FIELD_BIT_RESET     1'b0
`define ZERO_BYTE           8'h00

`endif

// File: logic/display_status_pkg.sv
// Types shared by the status readback block.
package display_status_pkg;

   typedef logic [7:0] byte_t;

   // Which status byte a read command selects.
   typedef enum logic [2:0] {
      QUERY_NONE,
      QUERY_ORIENT,
      QUERY_PIXFMT,
      QUERY_IMAGE,
      QUERY_SIGNAL
   } query_t;

endpackage

// File: logic/status_byte_select.sv
// Assembles the one parameter byte for a decoded status query.
`timescale 1ns/1ps
`include "display_status_defines.svh"

module status_byte_select
   import display_status_pkg::*;
(
   // Selected query
   input  wire query_t     query,
   // Orientation fields
   input  wire logic       bgr,
   input  wire logic       src_dir,
   input  wire logic       gate_scan_dir,
   // Pixel format and image mode fields
   input  wire logic [2:0] pixel_format_code,
   input  wire logic       all_on,
   input  wire logic       all_off,
   input  wire logic [2:0] gamma_sel,
   // Signal mode fields
   input  wire logic       te_on,
   input  wire logic       te_mode,
   input  wire logic       link_err,
   // Assembled byte
   output byte_t           status_byte
);

   // ==========================================================================
   // Byte images; every unlisted position is tied to zero.
   byte_t orient_byte;
   byte_t pixfmt_byte;
   byte_t image_byte;
   byte_t signal_byte;

   // Orientation byte carries colour order and both scan directions.
   assign orient_byte = {4'h0, bgr, 1'b0, src_dir, gate_scan_dir};
   assign pixfmt_byte = {5'h00, pixel_format_code};
   assign image_byte  = {3'h0, all_on, all_off, gamma_sel};
   assign signal_byte = {te_on, te_mode, 5'h00, link_err};

   // Selection; an unknown query yields zero, which nobody latches anyway.
   assign status_byte = (query == QUERY_ORIENT) ? orient_byte :
                        (query == QUERY_PIXFMT) ? pixfmt_byte :
                        (query == QUERY_IMAGE)  ? image_byte  :
                        (query == QUERY_SIGNAL) ? signal_byte : `ZERO_BYTE;

endmodule // status_byte_select

// File: tb/host_link_model.sv
// Host side of the link: issues status read commands and collects the answer byte.
`timescale 1ns/1ps

module host_link_model
   import display_status_pkg::*;
(
   // Clock
   input  wire logic  clk,
   // Request to the device
   output logic       cmd_valid,
   output byte_t      cmd_code,
   // Answer from the device
   input  wire logic  resp_valid,
   input  wire byte_t resp_data
);

   // ====================
   // Idle state
   initial begin
      cmd_valid = 1'b0;
      cmd_code  = 8'h00;
   end

   // ====================
   // One read request, one byte back.
   // The code is inverted after its slot, so a late sample of it cannot look valid.
   task automatic query(input byte_t code, output logic ok, output byte_t data);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_code  <= code;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_code  <= ~code;
      ok = (resp_valid === 1'b0);
      @(posedge clk);
      ok   = ok && (resp_valid === 1'b1);
      data = resp_data;
   endtask

   // Two requests on consecutive cycles; each answer is taken in the cycle it stands.
   // The valid strobe stays up across both slots, so it is never lowered and raised in one step.
   task automatic query_pair(input byte_t code_a, input byte_t code_b,
                             output logic ok, output byte_t data_a, output byte_t data_b);
      @(posedge clk);
      cmd_valid <= 1'b1;
      cmd_code  <= code_a;
      @(posedge clk);
      cmd_code  <= code_b;
      @(posedge clk);
      cmd_valid <= 1'b0;
      cmd_code  <= ~code_b;
      ok     = (resp_valid === 1'b1);
      data_a = resp_data;
      @(posedge clk);
      ok     = ok && (resp_valid === 1'b1);
      data_b = resp_data;
   endtask

endmodule // host_link_model

// File: tb/test_display_status_readback.sv
// Self-checking bench for the status readback block.
`timescale 1ns/1ps
`include "display_status_defines.svh"

module test_display_status_readback
   import display_status_pkg::*;
;

   // ====================
   // Stimulus and observation
   logic      clk        = 1'b0;
   logic      resetn     = 1'b0;
   byte_t     stb        = 8'h00;
   byte_t     dv         = 8'h00;
   logic      cmd_valid;
   byte_t     cmd_code;
   logic      resp_valid;
   byte_t     resp_data;
   logic      ok;
   byte_t     rd;
   byte_t     rd2;
   int        mismatches = 0;
   int        n_checks   = 0;
   int        cyc        = 0;
   byte_t     orient [4] = '{8'hff, 8'h02, 8'h01, 8'h08};

   // Strobes: 0 access control, 1 format, 2 image, 3 tear, 4 error, 5 ack, 6 soft reset.
   display_status_readback dut (
      .clk                        (clk),
      .resetn                     (resetn),
      .soft_reset                 (stb[6]),
      .cmd_valid                  (cmd_valid),
      .cmd_code                   (cmd_code),
      .memory_access_control_wr   (stb[0]),
      .memory_access_control_data (dv),
      .colour_format_setting_wr   (stb[1]),
      .colour_format_setting_data (dv[2:0]),
      .image_wr                   (stb[2]),
      .image_all_on               (dv[4]),
      .image_all_off              (dv[3]),
      .image_gamma                (dv[2:0]),
      .te_wr                      (stb[3]),
      .te_on_data                 (dv[7]),
      .te_mode_data               (dv[6]),
      .link_error                 (stb[4]),
      .ack_error_report           (stb[5]),
      .resp_valid                 (resp_valid),
      .resp_data                  (resp_data)
   );

   host_link_model host (
      .clk        (clk),
      .cmd_valid  (cmd_valid),
      .cmd_code   (cmd_code),
      .resp_valid (resp_valid),
      .resp_data  (resp_data)
   );

   // ====================
   // Clock and hang guard; the whole run needs well under a thousand cycles.
   always #2.5 clk = ~clk;

   always @(posedge clk) begin
      cyc++;
      if (cyc == 3000) begin
         mismatches++;
         finish_test();
      end
   end

   // ====================
   // Tasks
   task automatic chk(input byte_t got, input byte_t exp);
      n_checks++;
      if (got !== exp) begin
         mismatches++;
         $display("mismatch at %0t: got %h expected %h", $time, got, exp);
      end
   endtask

   // Strobes drop on the next edge, so every write lasts exactly one cycle.
   task automatic wr(input byte_t m, input byte_t d);
      @(posedge clk);
      stb <= m;
      dv  <= d;
      @(posedge clk);
      stb <= 8'h00;
   endtask

   task automatic q(input byte_t c, input byte_t e);
      host.query(c, ok, rd);
      chk({7'h00, ok}, 8'h01);
      chk(rd, e);
   endtask

   task automatic hw_reset();
      @(posedge clk);
      resetn <= 1'b0;
      repeat (8) @(posedge clk);
      resetn <= 1'b1;
   endtask

   task automatic defaults();
      q(`ORIENTATION_QUERY, 8'h00);
      q(`PIXEL_FORMAT_QUERY, 8'h07);
      q(`IMAGE_MODE_QUERY, 8'h00);
      q(`SIGNAL_MODE_QUERY, 8'h00);
   endtask

   task automatic finish_test();
      $display("checks %0d mismatches %0d", n_checks, mismatches);
      if (mismatches == 0 && n_checks > 0) begin
         $display("SIMULATION PASSED");
      end else begin
         $display("SIMULATION FAILED");
      end
      $finish;
   endtask

   // ====================
   // Main sequence
   initial begin
      hw_reset();
      defaults();
      foreach (orient[i]) begin
         wr(8'h01, orient[i]);
         q(`ORIENTATION_QUERY, orient[i] & 8'h0b);
      end
      for (int f = 5; f < 8; f++) begin
         wr(8'h02, byte_t'(f));
         q(`PIXEL_FORMAT_QUERY, byte_t'(f));
      end
      wr(8'h04, 8'h10);
      q(`IMAGE_MODE_QUERY, 8'h10);
      // A query taken in the cycle right after the write must already see the new flags.
      fork
         wr(8'h04, 8'h08);
         begin
            @(posedge clk);
            q(`IMAGE_MODE_QUERY, 8'h08);
         end
      join
      wr(8'h08, 8'hc0);
      q(`SIGNAL_MODE_QUERY, 8'hc0);
      wr(8'h08, 8'h80);
      q(`SIGNAL_MODE_QUERY, 8'h80);
      wr(8'h10, 8'h00);
      q(`SIGNAL_MODE_QUERY, 8'h81);
      wr(8'h20, 8'h00);
      q(`SIGNAL_MODE_QUERY, 8'h80);
      wr(8'h30, 8'h00);
      q(`SIGNAL_MODE_QUERY, 8'h81);
      // Back-to-back requests: one answer byte for each, in order.
      host.query_pair(`PIXEL_FORMAT_QUERY, `SIGNAL_MODE_QUERY, ok, rd, rd2);
      chk({7'h00, ok}, 8'h01);
      chk(rd, 8'h07);
      chk(rd2, 8'h81);
      host.query(8'h0a, ok, rd);
      chk({7'h00, ok}, 8'h00);
      // Soft reset arrives together with a write and an error event and must win.
      wr(8'h02, 8'h05);
      wr(8'h01, 8'h0b);
      wr(8'h51, 8'h0b);
      defaults();
      wr(8'h01, 8'h0b);
      hw_reset();
      defaults();
      finish_test();
   end

endmodule // test_display_status_readback
